// ===== logic/rmcs_device.sv
// Purpose: radio end, decodes command frames and sequences operating modes
// Assumes: link logic runs on the serial clock, core on ref_clk
// Notes: frame bytes are stable once select is high, core reads them then
`timescale 1ns/1ns
`default_nettype none
`include "rmcs_defs.svh"
module rmcs_device #(
  parameter int CAL_CYCLES = `RMCS_CAL_CYC
) (
  rmcs_if.dev                        lnk,
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic                  ce,
  input  wire logic                  chirpMode,
  input  wire logic                  preambleSeen,
  input  wire logic                  syncSeen,
  input  wire logic                  packetDone,
  input  wire logic                  scanDone,
  input  wire logic                  scanValid,
  input  wire logic                  scanIrqEnable,
  input  wire logic                  tcxoUsed,
  input  wire logic [23:0]           tcxoDelay,
  output rmcs_pkg::rmcs_dev_state_t  radioMode,
  output logic                       rxDoneIrq,
  output logic                       scanFinishedIrq,
  output logic                       activityFoundIrq,
  output logic                       rxTimerHalt,
  output logic                       contextSave,
  output logic                       contextRestore,
  output logic                       switcherOn,
  output logic [7:0]                 txPattern,
  output logic [6:0]                 calibrationMask
);
  // link domain
  logic [5:0]      bitCnt;      // bits in this frame
  logic [7:0]      shiftReg;    // byte being assembled
  logic [6:0][7:0] frameBytes;  // received bytes, index 0 is the opcode
  logic [2:0]      byteCnt;     // whole bytes received

  // core domain
  rmcs_pkg::rmcs_dev_state_t state;
  rmcs_pkg::rmcs_dev_state_t next_state;
  logic [2:0]  csSync;          // [0] feeds [1] only
  logic        csRise;
  logic        csFall;
  logic        wakeFrame;       // frame began while dozing
  logic        cmdGo;
  logic [7:0]  opcode;
  logic [7:0]  arg;
  logic        haltOnPreamble;  // halt event choice
  logic        regulatorChoice;
  logic [23:0] listenWindowCount;
  logic [23:0] dozeWindowCount;
  logic [25:0] winCnt;          // steps left in current window
  logic [9:0]  stepCnt;         // cycles within a step
  logic        winDone;
  logic [31:0] calCnt;
  logic        calDone;
  logic        winLoad;
  logic [25:0] winValue;

  // pick one of the two 24-bit parameters
  function automatic logic [23:0] paramWord(input logic [6:0][7:0] f, input logic second);
    paramWord = second ? {f[4], f[5], f[6]} : {f[1], f[2], f[3]};
  endfunction

  // bit counter ends with the frame's own select
  always_ff @(posedge lnk.sclk or posedge lnk.chipSelectN) begin
    if (lnk.chipSelectN) begin
      bitCnt <= 6'h00;
    end else if (bitCnt != `RMCS_FRAME_BITS) begin
      bitCnt <= bitCnt + 6'h01;
    end
  end

  // byte assembly, first byte is the opcode
  always_ff @(posedge lnk.sclk) begin
    if (!lnk.chipSelectN && bitCnt != `RMCS_FRAME_BITS) begin
      shiftReg <= {shiftReg[6:0], lnk.mosi};
      if (bitCnt == 6'h00) begin
        byteCnt <= 3'h0;
      end
      if (bitCnt[2:0] == 3'h7) begin
        frameBytes[bitCnt[5:3]] <= {shiftReg[6:0], lnk.mosi};
        byteCnt                 <= bitCnt[5:3] + 3'h1;
      end
    end
  end

  // select crosses into the core domain
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      csSync <= 3'h7;
    end else if (ce) begin
      csSync <= {csSync[1:0], lnk.chipSelectN};
    end
  end
  assign csRise = csSync[1] & ~csSync[2];
  assign csFall = ~csSync[1] & csSync[2];

  // a frame opened during doze only wakes the device
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wakeFrame <= 1'b0;
    end else if (ce) begin
      if (csFall) begin
        wakeFrame <= (state == rmcs_pkg::ST_DOZE);
      end else if (csRise) begin
        wakeFrame <= 1'b0;
      end
    end
  end

  // frame is read only after select rose, bytes are then still
  assign cmdGo  = ce && csRise && !wakeFrame && byteCnt != 3'h0;
  assign opcode = frameBytes[0];
  assign arg    = frameBytes[1];

  // mode sequencing
  always_comb begin
    next_state = state;
    case (state)
      rmcs_pkg::ST_BOOTCAL, rmcs_pkg::ST_CALIB: begin
        if (calDone) next_state = rmcs_pkg::ST_IDLE_RC;
      end
      rmcs_pkg::ST_LISTEN: begin
        if (packetDone) next_state = rmcs_pkg::ST_IDLE_RC;
        else if (syncSeen) next_state = rmcs_pkg::ST_GETPKT;
        else if (preambleSeen) next_state = rmcs_pkg::ST_SEARCH;
        else if (winDone) next_state = rmcs_pkg::ST_DOZE;
      end
      rmcs_pkg::ST_SEARCH: begin
        if (packetDone) next_state = rmcs_pkg::ST_IDLE_RC;
        else if (syncSeen) next_state = rmcs_pkg::ST_GETPKT;
        else if (winDone && !haltOnPreamble) next_state = rmcs_pkg::ST_DOZE;
      end
      rmcs_pkg::ST_GETPKT: begin
        if (packetDone) next_state = rmcs_pkg::ST_IDLE_RC;
      end
      rmcs_pkg::ST_DOZE: begin
        if (csFall) next_state = rmcs_pkg::ST_IDLE_RC;
        else if (winDone) next_state = tcxoUsed ? rmcs_pkg::ST_WARM : rmcs_pkg::ST_LISTEN;
      end
      rmcs_pkg::ST_WARM: begin
        if (winDone) next_state = rmcs_pkg::ST_LISTEN;
      end
      rmcs_pkg::ST_SCAN: begin
        if (scanDone) next_state = rmcs_pkg::ST_IDLE_RC;
      end
      default: ;
    endcase
    if (cmdGo && state != rmcs_pkg::ST_BOOTCAL && state != rmcs_pkg::ST_CALIB) begin
      case (opcode)
        `RMCS_OP_IDLE: begin
          if (byteCnt >= 3'h2) next_state = arg[0] ? rmcs_pkg::ST_IDLE_XO : rmcs_pkg::ST_IDLE_RC;
        end
        `RMCS_OP_LISTEN: begin
          if (state == rmcs_pkg::ST_IDLE_RC && byteCnt == `RMCS_LISTEN_LEN) next_state = rmcs_pkg::ST_LISTEN;
        end
        `RMCS_OP_SCAN: begin
          if (chirpMode) next_state = rmcs_pkg::ST_SCAN;
        end
        `RMCS_OP_TONE:   next_state = rmcs_pkg::ST_TONE;
        `RMCS_OP_PREAMB: next_state = rmcs_pkg::ST_PREAMB;
        `RMCS_OP_CAL: begin
          if (state == rmcs_pkg::ST_IDLE_RC && byteCnt >= 3'h2 && arg[6:0] != 7'h00) next_state = rmcs_pkg::ST_CALIB;
        end
        default: ;
      endcase
    end
  end

  // power-up starts in calibration
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= rmcs_pkg::ST_BOOTCAL;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // configuration taken from commands
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      haltOnPreamble    <= 1'b0;
      regulatorChoice   <= 1'b0;
      calibrationMask   <= `RMCS_BOOT_CAL_MASK;
      listenWindowCount <= 24'h000000;
      dozeWindowCount   <= 24'h000000;
    end else if (cmdGo && byteCnt >= 3'h2 && state != rmcs_pkg::ST_BOOTCAL && state != rmcs_pkg::ST_CALIB) begin
      // settings arriving while calibrating are dropped, like the mode change
      if (opcode == `RMCS_OP_HALT) haltOnPreamble <= arg[0];
      if (opcode == `RMCS_OP_REG) regulatorChoice <= arg[0];
      if (next_state == rmcs_pkg::ST_CALIB) calibrationMask <= arg[6:0];
      if (opcode == `RMCS_OP_LISTEN && next_state == rmcs_pkg::ST_LISTEN) begin
        listenWindowCount <= paramWord(frameBytes, 1'b0);
        dozeWindowCount   <= paramWord(frameBytes, 1'b1);
      end
    end
  end

  // window length chosen at each state entry
  always_comb begin
    winLoad  = next_state != state;
    winValue = 26'h0;
    case (next_state)
      rmcs_pkg::ST_LISTEN: winValue = {2'h0, (state == rmcs_pkg::ST_IDLE_RC) ? paramWord(frameBytes, 1'b0)
                                                                              : listenWindowCount};
      rmcs_pkg::ST_SEARCH: winValue = {1'b0, listenWindowCount, 1'b0} + {2'h0, dozeWindowCount};
      rmcs_pkg::ST_DOZE:   winValue = {2'h0, dozeWindowCount};
      rmcs_pkg::ST_WARM:   winValue = {2'h0, tcxoDelay};
      default:             winValue = 26'h0;
    endcase
  end

  // step timer, one step is 15.625 us of core clock
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      winCnt  <= 26'h0;
      stepCnt <= 10'h000;
    end else if (ce) begin
      if (winLoad) begin
        winCnt  <= winValue;
        stepCnt <= 10'h000;
      end else if (winCnt != 26'h0) begin
        if (stepCnt == 10'(`RMCS_STEP_CYC - 1)) begin
          stepCnt <= 10'h000;
          winCnt  <= winCnt - 26'h1;
        end else begin
          stepCnt <= stepCnt + 10'h001;
        end
      end
    end
  end
  assign winDone = winCnt == 26'h0;

  // calibration run time, covers every block
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      calCnt <= 32'(CAL_CYCLES);
    end else if (ce) begin
      if (next_state == rmcs_pkg::ST_CALIB && state != rmcs_pkg::ST_CALIB) calCnt <= 32'(CAL_CYCLES);
      else if (calCnt != 32'h0) calCnt <= calCnt - 32'h1;
    end
  end
  assign calDone = calCnt == 32'h0;

  // event pulses and registered outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      radioMode        <= rmcs_pkg::ST_BOOTCAL;
      lnk.busy         <= 1'b1;
      rxDoneIrq        <= 1'b0;
      scanFinishedIrq  <= 1'b0;
      activityFoundIrq <= 1'b0;
      rxTimerHalt      <= 1'b0;
      contextSave      <= 1'b0;
      contextRestore   <= 1'b0;
      switcherOn       <= 1'b0;
      txPattern        <= 8'h00;
    end else if (ce) begin
      radioMode <= next_state;
      // busy also covers the cycle a command executes
      lnk.busy <= cmdGo || next_state == rmcs_pkg::ST_BOOTCAL || next_state == rmcs_pkg::ST_CALIB
                  || next_state == rmcs_pkg::ST_DOZE;
      rxDoneIrq <= packetDone && (state == rmcs_pkg::ST_LISTEN || state == rmcs_pkg::ST_SEARCH
                   || state == rmcs_pkg::ST_GETPKT);
      scanFinishedIrq  <= state == rmcs_pkg::ST_SCAN && scanDone && scanIrqEnable;
      activityFoundIrq <= state == rmcs_pkg::ST_SCAN && scanDone && scanValid;
      rxTimerHalt <= (state == rmcs_pkg::ST_LISTEN || state == rmcs_pkg::ST_SEARCH)
                     && (haltOnPreamble ? preambleSeen : syncSeen);
      contextSave    <= next_state != state && (next_state == rmcs_pkg::ST_DOZE
                        || (state == rmcs_pkg::ST_IDLE_RC && next_state == rmcs_pkg::ST_LISTEN));
      contextRestore <= state == rmcs_pkg::ST_DOZE && next_state != rmcs_pkg::ST_DOZE;
      // switching converter only outside RC idle and sleep
      switcherOn <= regulatorChoice && (next_state == rmcs_pkg::ST_IDLE_XO || next_state == rmcs_pkg::ST_LISTEN
                    || next_state == rmcs_pkg::ST_SEARCH || next_state == rmcs_pkg::ST_GETPKT
                    || next_state == rmcs_pkg::ST_SCAN || next_state == rmcs_pkg::ST_TONE
                    || next_state == rmcs_pkg::ST_PREAMB);
      txPattern <= (next_state == rmcs_pkg::ST_PREAMB && !chirpMode) ? `RMCS_FSK_PREAMBLE : 8'h00;
    end
  end
endmodule
`default_nettype wire

// ===== logic/rmcs_host.sv
// Purpose: host end, sends command frames over the serial link
// Assumes: cmdLen is 1 to 7, byte 0 sits in cmdFrame[55:48]
// Notes: serial clock is ref_clk divided by twice the half count
`timescale 1ns/1ns
`default_nettype none
`include "rmcs_defs.svh"
module rmcs_host (
  rmcs_if.hst             lnk,
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        cmdValid,
  output logic             cmdReady,
  input  wire logic [55:0] cmdFrame,
  input  wire logic [2:0]  cmdLen,
  input  wire logic        wakeReq,
  output logic             busySeen
);
  rmcs_pkg::rmcs_host_state_t state;  // sequencing state
  logic [1:0]  busySync;              // [0] feeds [1] only
  logic [55:0] shiftReg;              // outgoing bits
  logic [5:0]  bitLeft;               // bits still to send
  logic [7:0]  divCnt;                // clock divider and guard timer
  logic        csN;
  logic        sclkR;
  logic        mosiR;

  assign lnk.sclk        = sclkR;
  assign lnk.chipSelectN = csN;
  assign lnk.mosi        = mosiR;
  assign busySeen        = busySync[1];

  // new frame only when device reports ready
  assign cmdReady = ce && (state == rmcs_pkg::H_IDLE) && !busySync[1] && !wakeReq;

  // busy comes from another clock domain
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busySync <= 2'h3;
    end else if (ce) begin
      busySync <= {busySync[0], lnk.busy};
    end
  end

  // frame sequencing and clock divider
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state    <= rmcs_pkg::H_IDLE;
      csN      <= 1'b1;
      sclkR    <= 1'b0;
      mosiR    <= 1'b0;
      shiftReg <= 56'h0;
      bitLeft  <= 6'h00;
      divCnt   <= 8'h00;
    end else if (ce) begin
      case (state)
        rmcs_pkg::H_IDLE: begin
          divCnt <= 8'h00;
          if (wakeReq) begin
            // a bare falling select edge wakes a dozing device
            csN   <= 1'b0;
            state <= rmcs_pkg::H_WAKE;
          end else if (cmdReady && cmdValid && cmdLen != 3'h0) begin
            // opcode goes first, parameters follow
            csN      <= 1'b0;
            shiftReg <= cmdFrame;
            mosiR    <= cmdFrame[55];
            bitLeft  <= {cmdLen, 3'h0};
            state    <= rmcs_pkg::H_SHIFT;
          end
        end
        rmcs_pkg::H_SHIFT: begin
          if (divCnt == `RMCS_SCLK_HALF - 8'h01) begin
            divCnt <= 8'h00;
            if (!sclkR) begin
              sclkR <= 1'b1;
            end else begin
              // data changes only while the clock is low
              sclkR    <= 1'b0;
              shiftReg <= {shiftReg[54:0], 1'b0};
              mosiR    <= shiftReg[54];
              bitLeft  <= bitLeft - 6'h01;
              if (bitLeft == 6'h01) begin
                state <= rmcs_pkg::H_TAIL;
              end
            end
          end else begin
            divCnt <= divCnt + 8'h01;
          end
        end
        rmcs_pkg::H_TAIL, rmcs_pkg::H_WAKE: begin
          if (divCnt == `RMCS_SCLK_HALF - 8'h01) begin
            // rising select tells the device to execute
            csN    <= 1'b1;
            divCnt <= 8'h00;
            state  <= rmcs_pkg::H_GUARD;
          end else begin
            divCnt <= divCnt + 8'h01;
          end
        end
        rmcs_pkg::H_GUARD: begin
          // let the device raise busy before it is trusted again
          if (divCnt == `RMCS_HOST_GUARD) begin
            state <= rmcs_pkg::H_IDLE;
          end else begin
            divCnt <= divCnt + 8'h01;
          end
        end
        default: state <= rmcs_pkg::H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== pkg/rmcs_defs.svh
// Purpose: shared constants for the radio mode command sequencer
// Assumes: 50 MHz core clock on both ends
// Notes: opcodes, field values and timing counts
`ifndef RMCS_DEFS_SVH
`define RMCS_DEFS_SVH

// opcodes
`define RMCS_OP_IDLE     8'h80
`define RMCS_OP_HALT     8'h9f
`define RMCS_OP_LISTEN   8'h94
`define RMCS_OP_SCAN     8'hc5
`define RMCS_OP_TONE     8'hd1
`define RMCS_OP_PREAMB   8'hd2
`define RMCS_OP_REG      8'h96
`define RMCS_OP_CAL      8'h89

// frame geometry
`define RMCS_FRAME_BYTES 7
`define RMCS_FRAME_BITS  6'h38
`define RMCS_LISTEN_LEN  3'h7

// field values
`define RMCS_BOOT_CAL_MASK 7'h3f
`define RMCS_FSK_PREAMBLE  8'h55

// timing
`define RMCS_CLK_NS      20
`define RMCS_STEP_NS     15625
`define RMCS_STEP_CYC    ((`RMCS_STEP_NS) / (`RMCS_CLK_NS))
`define RMCS_CAL_US      3500
`define RMCS_CAL_CYC     ((`RMCS_CAL_US * 1000) / (`RMCS_CLK_NS))
`define RMCS_SCLK_HALF   8'h02
`define RMCS_HOST_GUARD  8'h08

`endif

// ===== pkg/rmcs_if.sv
// Purpose: serial command link between host and radio sequencer
// Assumes: host drives the serial clock, mode 0 sampling
// Notes: busy is driven by the device
`timescale 1ns/1ns
`default_nettype none
interface rmcs_if;
  logic sclk;         // serial clock from host
  logic chipSelectN;  // frame select, active low
  logic mosi;         // command data, msb first
  logic busy;         // device not ready

  modport dev (
    input  sclk,
    input  chipSelectN,
    input  mosi,
    output busy
  );

  modport hst (
    output sclk,
    output chipSelectN,
    output mosi,
    input  busy
  );
endinterface
`default_nettype wire

// ===== pkg/rmcs_pkg.sv
// Purpose: types for the radio mode command sequencer
// Assumes: one-hot state codes
// Notes: shared by both ends
`default_nettype none
package rmcs_pkg;

  // device operating modes
  typedef enum logic [11:0] {
    ST_BOOTCAL = 12'h001,
    ST_IDLE_RC = 12'h002,
    ST_IDLE_XO = 12'h004,
    ST_LISTEN  = 12'h008,
    ST_SEARCH  = 12'h010,
    ST_GETPKT  = 12'h020,
    ST_DOZE    = 12'h040,
    ST_WARM    = 12'h080,
    ST_SCAN    = 12'h100,
    ST_TONE    = 12'h200,
    ST_PREAMB  = 12'h400,
    ST_CALIB   = 12'h800
  } rmcs_dev_state_t;

  // host sequencing
  typedef enum logic [4:0] {
    H_IDLE  = 5'h01,
    H_SHIFT = 5'h02,
    H_TAIL  = 5'h04,
    H_WAKE  = 5'h08,
    H_GUARD = 5'h10
  } rmcs_host_state_t;

endpackage
`default_nettype wire

// ===== verification/rmcs_link_asserts.sv
// Purpose: protocol checks on the serial link between host and radio ends
// Assumes: host derives sclk from ref_clk, busy is a ref_clk register
// Notes: sees the link signals only; no bind, instantiated beside the link
`timescale 1ns/1ns
`default_nettype none
module rmcs_link_asserts (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic chipSelectN,
  input wire logic mosi,
  input wire logic busy
);
  logic [7:0] bitCnt; // sclk rises seen in the current frame
  logic       sclkQ;  // sclk one ref_clk back, for edge finding

  // count serial clock rises; cleared between frames so wake frames count zero
  always_ff @(posedge ref_clk) begin
    sclkQ <= sclk;
    if (reset || chipSelectN) begin
      bitCnt <= 8'h00;
    end else if (sclk && !sclkQ) begin
      bitCnt <= bitCnt + 8'h01;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_sclk_idle_low: assert property (chipSelectN |-> !sclk)
    else $error("serial clock moves outside a frame");
  a_mosi_stable: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("data line changes while serial clock is high");
  a_sclk_half: assert property ($rose(sclk) |=> sclk ##1 !sclk)
    else $error("serial clock high phase is not two cycles");
  a_frame_bound: assert property ($fell(chipSelectN) |-> ##[1:240] $rose(chipSelectN))
    else $error("frame longer than seven bytes");
  a_whole_bytes: assert property ($rose(chipSelectN) |-> bitCnt[2:0] == 3'h0 && bitCnt <= 8'h38)
    else $error("frame ends on a partial byte");
  a_guard_gap: assert property ($rose(chipSelectN) |-> chipSelectN[*8])
    else $error("next frame starts inside the guard time");
  a_boot_busy: assert property ($fell(reset) |-> busy[*8])
    else $error("busy drops during power-up calibration");
  a_boot_quiet: assert property ($fell(reset) |-> chipSelectN[*8])
    else $error("host selects the device during power-up calibration");

  // main traffic kinds
  c_full_frame: cover property ($rose(chipSelectN) && bitCnt == 8'h38);
  c_wake_frame: cover property ($rose(chipSelectN) && bitCnt == 8'h00);
  c_busy_end: cover property ($fell(busy));
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Purpose: self-checking bench joining host and radio ends over the link
// Assumes: calibration shortened to 50 cycles, one step is 781 cycles
// Notes: mode changes and pulses are compared against queued notes
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin failures++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
  localparam logic [5:0] P_RX = 6'h20, P_SF = 6'h10, P_AF = 6'h08, P_HALT = 6'h04, P_SAVE = 6'h02, P_REST = 6'h01;
  logic                      ref_clk = 1'b0;
  logic                      reset = 1'b1;
  logic                      cmdValid = 1'b0;
  logic [55:0]               cmdFrame = 56'h0;
  logic [2:0]                cmdLen = 3'h0;
  logic                      wakeReq = 1'b0;
  logic                      chirpMode = 1'b0;
  logic [3:0]                ev = 4'h0;        // preamble, sync, packet, scan end
  logic                      scanValid = 1'b0;
  logic                      scanIrqEnable = 1'b1;
  logic                      tcxoUsed = 1'b0;
  logic                      cmdReady, busySeen, rxDoneIrq, scanFinishedIrq, activityFoundIrq;
  logic                      rxTimerHalt, contextSave, contextRestore, switcherOn;
  logic [7:0]                txPattern, mask;
  logic [6:0]                calibrationMask;
  logic [5:0]                pulses, expPulse;
  rmcs_pkg::rmcs_dev_state_t radioMode, lastMode, expMode;
  rmcs_pkg::rmcs_dev_state_t modeQ[$];          // expected mode sequence
  logic [5:0]                pulseQ[$];         // expected pulse sets
  int                        failures = 0, checked = 0, n = 0, waitCyc = 0;
  int                        seed = 32'h5d5d60bd;

  rmcs_if lnk();
  rmcs_host i_rmcs_host (.lnk(lnk), .ref_clk(ref_clk), .reset(reset), .ce(1'b1), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdFrame(cmdFrame), .cmdLen(cmdLen), .wakeReq(wakeReq), .busySeen(busySeen));
  rmcs_device #(.CAL_CYCLES(50)) i_rmcs_device (.lnk(lnk), .ref_clk(ref_clk), .reset(reset), .ce(1'b1),
    .chirpMode(chirpMode), .preambleSeen(ev[3]), .syncSeen(ev[2]), .packetDone(ev[1]), .scanDone(ev[0]),
    .scanValid(scanValid), .scanIrqEnable(scanIrqEnable), .tcxoUsed(tcxoUsed), .tcxoDelay(24'h000001),
    .radioMode(radioMode), .rxDoneIrq(rxDoneIrq), .scanFinishedIrq(scanFinishedIrq),
    .activityFoundIrq(activityFoundIrq), .rxTimerHalt(rxTimerHalt), .contextSave(contextSave),
    .contextRestore(contextRestore), .switcherOn(switcherOn), .txPattern(txPattern),
    .calibrationMask(calibrationMask));
  rmcs_link_asserts chk (.ref_clk(ref_clk), .reset(reset), .sclk(lnk.sclk), .chipSelectN(lnk.chipSelectN),
    .mosi(lnk.mosi), .busy(lnk.busy));

  assign pulses = {rxDoneIrq, scanFinishedIrq, activityFoundIrq, rxTimerHalt, contextSave, contextRestore};

  // free-running core clock, 20 ns
  always #10 ref_clk = ~ref_clk;

  // one frame; returns once the host is ready again, so the command has run
  task automatic send(input logic [55:0] f, input logic [2:0] len);
    waitCyc = 0;
    while (cmdReady !== 1'b1 && waitCyc < 5000) begin
      @(negedge ref_clk);
      waitCyc++;
    end
    if (waitCyc >= 5000) failures++;
    cmdFrame = f;
    cmdLen = len;
    cmdValid = 1'b1;
    @(negedge ref_clk);
    cmdValid = 1'b0;
    waitCyc = 0;
    while (cmdReady !== 1'b1 && waitCyc < 5000) begin
      @(negedge ref_clk);
      waitCyc++;
    end
    // a host that never comes back counts as a mismatch
    if (waitCyc >= 5000) failures++;
  endtask

  // bounded wait for a mode; n holds the cycles spent
  task automatic wait_mode(input rmcs_pkg::rmcs_dev_state_t m);
    n = 0;
    while (radioMode !== m && n < 30000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 30000) failures++;
  endtask

  // one-cycle radio event pulse
  task automatic strobe(input logic [3:0] v);
    ev = v;
    @(negedge ref_clk);
    ev = 4'h0;
  endtask

  task automatic wrap_up;
    $display("TB: checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // compare every mode change and every pulse set against the oldest note;
  // an unexpected change meets an empty queue and fails
  always @(posedge ref_clk) begin
    if (!reset && radioMode !== lastMode) begin
      expMode = (modeQ.size() != 0) ? modeQ.pop_front() : rmcs_pkg::rmcs_dev_state_t'(12'h000);
      `CHK(radioMode, expMode)
    end
    if (!reset && pulses !== 6'h00) begin
      expPulse = (pulseQ.size() != 0) ? pulseQ.pop_front() : 6'h00;
      `CHK(pulses, expPulse)
    end
    lastMode = radioMode;
  end

  // watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    failures++;
    wrap_up();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    modeQ.push_back(rmcs_pkg::ST_IDLE_RC);
    `CHK(calibrationMask, 7'h3f)
    `CHK(switcherOn, 1'b0)
    // crystal idle with the converter on, then off, back to rc idle
    modeQ.push_back(rmcs_pkg::ST_IDLE_XO);
    send({8'h80, 8'h01, 40'h0}, 3'h2);
    send({8'h96, 8'h01, 40'h0}, 3'h2);
    `CHK(switcherOn, 1'b1)
    send({8'h96, 8'h00, 40'h0}, 3'h2);
    `CHK(switcherOn, 1'b0)
    modeQ.push_back(rmcs_pkg::ST_IDLE_RC);
    send({8'h80, 8'h00, 40'h0}, 3'h2);
    // calibration with a random mask, top bit kept zero
    mask = {1'b0, 7'($random(seed)) | 7'h01};
    modeQ.push_back(rmcs_pkg::ST_CALIB);
    modeQ.push_back(rmcs_pkg::ST_IDLE_RC);
    send({8'h89, mask, 40'h0}, 3'h2);
    `CHK(calibrationMask, mask[6:0])
    // two-byte frame alone is 64 cycles; busy for calibration adds 50 more
    `CHK(waitCyc >= 114, 1'b1)
    // tone, endless preamble, refused scan outside chirp
    modeQ.push_back(rmcs_pkg::ST_TONE);
    send({8'hd1, 48'h0}, 3'h1);
    modeQ.push_back(rmcs_pkg::ST_PREAMB);
    send({8'hd2, 48'h0}, 3'h1);
    `CHK(txPattern, 8'h55)
    send({8'hc5, 48'h0}, 3'h1);
    // chirp preamble carries no byte pattern
    chirpMode = 1'b1;
    @(negedge ref_clk);
    `CHK(txPattern, 8'h00)
    modeQ.push_back(rmcs_pkg::ST_IDLE_RC);
    send({8'h80, 8'h00, 40'h0}, 3'h2);
    // three scans: found, none, found with the done flag disabled
    for (int i = 0; i < 3; i++) begin
      scanValid = (i != 1);
      scanIrqEnable = (i != 2);
      modeQ.push_back(rmcs_pkg::ST_SCAN);
      modeQ.push_back(rmcs_pkg::ST_IDLE_RC);
      pulseQ.push_back((i == 0) ? (P_SF | P_AF) : ((i == 1) ? P_SF : P_AF));
      send({8'hc5, 48'h0}, 3'h1);
      strobe(4'h1);
      wait_mode(rmcs_pkg::ST_IDLE_RC);
    end
    chirpMode = 1'b0;
    // listen loop, halt on sync: listen 2 steps, doze 1 step
    modeQ = {modeQ, rmcs_pkg::ST_LISTEN, rmcs_pkg::ST_DOZE, rmcs_pkg::ST_LISTEN};
    modeQ = {modeQ, rmcs_pkg::ST_SEARCH, rmcs_pkg::ST_GETPKT, rmcs_pkg::ST_IDLE_RC};
    pulseQ = {pulseQ, P_SAVE, P_SAVE, P_REST, P_HALT, P_RX};
    send({8'h94, 24'h000002, 24'h000001}, 3'h7);
    wait_mode(rmcs_pkg::ST_DOZE);
    `CHK(n inside {[1530:1570]}, 1'b1)
    wait_mode(rmcs_pkg::ST_LISTEN);
    `CHK(n inside {[775:790]}, 1'b1)
    strobe(4'h8);
    repeat (4) @(negedge ref_clk);
    strobe(4'h4);
    repeat (4) @(negedge ref_clk);
    strobe(4'h2);
    wait_mode(rmcs_pkg::ST_IDLE_RC);
    // halt on preamble with oscillator warm-up, then idle ends the loop
    tcxoUsed = 1'b1;
    send({8'h9f, 8'h01, 40'h0}, 3'h2);
    modeQ = {modeQ, rmcs_pkg::ST_LISTEN, rmcs_pkg::ST_DOZE, rmcs_pkg::ST_WARM, rmcs_pkg::ST_LISTEN};
    modeQ = {modeQ, rmcs_pkg::ST_SEARCH, rmcs_pkg::ST_IDLE_RC};
    pulseQ = {pulseQ, P_SAVE, P_SAVE, P_REST, P_HALT};
    send({8'h94, 24'h000001, 24'h000001}, 3'h7);
    wait_mode(rmcs_pkg::ST_WARM);
    wait_mode(rmcs_pkg::ST_LISTEN);
    `CHK(n inside {[775:790]}, 1'b1)
    strobe(4'h8);
    repeat (2400) @(negedge ref_clk);
    send({8'h80, 8'h00, 40'h0}, 3'h2);
    // doze is cut short by a bare wake frame well before its 3-step window ends
    tcxoUsed = 1'b0;
    modeQ = {modeQ, rmcs_pkg::ST_LISTEN, rmcs_pkg::ST_DOZE, rmcs_pkg::ST_IDLE_RC};
    pulseQ = {pulseQ, P_SAVE, P_SAVE, P_REST};
    send({8'h94, 24'h000001, 24'h000003}, 3'h7);
    wait_mode(rmcs_pkg::ST_DOZE);
    repeat (3) @(negedge ref_clk);
    `CHK(busySeen, 1'b1)
    wakeReq = 1'b1;
    @(negedge ref_clk);
    wakeReq = 1'b0;
    wait_mode(rmcs_pkg::ST_IDLE_RC);
    repeat (20) @(negedge ref_clk);
    `CHK(modeQ.size() + pulseQ.size(), 0)
    wrap_up();
  end
endmodule
`default_nettype wire
